// ### logic/sml_defs.svh
// Purpose: Constants for the configuration latch and status indicator block
// Assumes: 125 MHz system clock
// Notes: Offsets are byte addresses on the register bus
`ifndef SML_DEFS_SVH
`define SML_DEFS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SML_CLK_HZ 125000000
`define SML_FLASH_HALF_MS 250
`define SML_FLASH_HALF_CYC ((`SML_CLK_HZ / 1000) * `SML_FLASH_HALF_MS)

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SML_OFS_CTRL 8'h00
`define SML_OFS_STATUS 8'h04
`define SML_OFS_SEL 8'h08
`define SML_OFS_LED 8'h0c

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define SML_ST_CFG_ERR 0
`define SML_ST_GEN_ERR 1
`define SML_ST_ALERT 2
`define SML_ST_SAFE 3
`define SML_ST_CAPTURED 4

// ----------------------------------------
// Widths
// ----------------------------------------
`define SML_SEL_W 4
`define SML_IN_N 4

`endif

// ### logic/sml_pkg.sv
// Purpose: Types for the configuration latch and status indicator block
// Assumes: sml_defs.svh provides widths
// Notes: Indicator bundle travels as one packed struct
`include "sml_defs.svh"

package sml_pkg;

	// ----------------------------------------
	// Indicator bundle
	// ----------------------------------------
	typedef struct packed {
		logic state;
		logic start;
		logic error;
		logic [`SML_IN_N-1:0] inputs;
	} sml_led_s;

endpackage

// ### logic/sml_top.sv
// Purpose: Selector latch, configuration check, safe state and indicator drive
// Assumes: All inputs synchronous to clk_i; rst_i stands for power-up
// Notes: Registers over classic Wishbone, ack one cycle after the request
//
// Notes on behaviour
// - Selectors are captured once after power-up and held for the session.
// - Live selectors differing from captured values raise a configuration error.
// - Output indicator is dark when output is off, lit when on.
// - Start indicator dark unmet, lit met, flashing while waiting.
// - Each safety input indicator follows its input level.
// - Sync timeout flashes error indicator; inputs 0 and 1 flash alternately.
// - Any alert forces the safe state with outputs deenergized.
// - Once the alert cause clears, normal operation resumes without power cycle.
// - Detected errors light error steadily and hold safe state until power-up.
// - Configuration error lights output, start and input indicators steadily.
`timescale 1ns/1ps
`include "sml_defs.svh"

module sml_top #(
	parameter logic [31:0] FLASH_HALF_CYC = `SML_FLASH_HALF_CYC
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Configuration selectors
	input wire logic [`SML_SEL_W-1:0] app_sel_i,
	input wire logic [`SML_SEL_W-1:0] start_sel_i,
	// Device status
	input wire logic out_request_i,
	input wire logic start_met_i,
	input wire logic start_wait_i,
	input wire logic [`SML_IN_N-1:0] in_active_i,
	input wire logic sync_timeout_i,
	input wire logic alert_i,
	input wire logic error_i,
	// Outputs
	output logic safe_out_o,
	output logic safe_state_o,
	output sml_pkg::sml_led_s led_o
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic captured;
	logic [`SML_SEL_W-1:0] app_lat;
	logic [`SML_SEL_W-1:0] start_lat;
	logic err_cfg;
	logic err_gen;
	logic [31:0] flash_half;
	logic [31:0] flash_cnt;
	logic flash_ph;
	logic mismatch;
	logic alert;
	logic next_err_cfg;
	logic next_err_gen;
	logic next_safe;
	logic next_safe_out;
	logic wb_req;
	sml_pkg::sml_led_s next_led;

	// ----------------------------------------
	// Selector capture
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			captured <= 1'b0;
			app_lat <= '0;
			start_lat <= '0;
		end else if (ce_i && !captured) begin
			captured <= 1'b1;
			app_lat <= app_sel_i;
			start_lat <= start_sel_i;
		end
	end

	assign mismatch = captured && ((app_sel_i != app_lat) || (start_sel_i != start_lat));
	assign alert = sync_timeout_i || alert_i;
	assign next_err_cfg = err_cfg || mismatch;
	assign next_err_gen = err_gen || error_i;
	assign next_safe = !captured || alert || next_err_cfg || next_err_gen;
	assign next_safe_out = out_request_i && !next_safe;

	// ----------------------------------------
	// Error latches
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			err_cfg <= 1'b0;
			err_gen <= 1'b0;
		end else if (ce_i) begin
			err_cfg <= next_err_cfg;
			err_gen <= next_err_gen;
		end
	end

	// ----------------------------------------
	// Common flash timebase
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flash_cnt <= '0;
			flash_ph <= 1'b0;
		end else if (ce_i) begin
			if (flash_cnt + 32'h1 >= flash_half) begin
				flash_cnt <= '0;
				flash_ph <= !flash_ph;
			end else begin
				flash_cnt <= flash_cnt + 32'h1;
			end
		end
	end

	// ----------------------------------------
	// Indicator pattern
	// ----------------------------------------
	always_comb begin
		next_led.state = next_safe_out;
		next_led.start = start_met_i || (start_wait_i && flash_ph);
		next_led.inputs = in_active_i;
		next_led.error = 1'b0;
		if (alert) begin
			next_led.error = flash_ph;
		end
		if (sync_timeout_i) begin
			next_led.inputs[0] = flash_ph;
			next_led.inputs[1] = !flash_ph;
		end
		if (next_err_gen) begin
			next_led.error = 1'b1;
		end
		if (next_err_cfg) begin
			next_led.error = 1'b1;
			next_led.state = 1'b1;
			next_led.start = 1'b1;
			next_led.inputs = '1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			led_o <= '0;
			safe_out_o <= 1'b0;
			safe_state_o <= 1'b1;
		end else if (ce_i) begin
			led_o <= next_led;
			safe_out_o <= next_safe_out;
			safe_state_o <= next_safe;
		end
	end

	// ----------------------------------------
	// Wishbone registers
	// ----------------------------------------
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flash_half <= FLASH_HALF_CYC;
		end else if (ce_i && wb_req && wb_we_i && wb_adr_i == `SML_OFS_CTRL) begin
			for (int b = 0; b < 4; b++) begin
				if (wb_sel_i[b]) begin
					flash_half[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else if (ce_i) begin
			wb_ack_o <= wb_req;
			wb_dat_o <= '0;
			if (wb_req && !wb_we_i) begin
				unique case (wb_adr_i)
					`SML_OFS_CTRL: wb_dat_o <= flash_half;
					`SML_OFS_STATUS: begin
						wb_dat_o[`SML_ST_CFG_ERR] <= err_cfg;
						wb_dat_o[`SML_ST_GEN_ERR] <= err_gen;
						wb_dat_o[`SML_ST_ALERT] <= alert;
						wb_dat_o[`SML_ST_SAFE] <= safe_state_o;
						wb_dat_o[`SML_ST_CAPTURED] <= captured;
					end
					`SML_OFS_SEL: wb_dat_o[2*`SML_SEL_W-1:0] <= {start_lat, app_lat};
					`SML_OFS_LED: wb_dat_o[$bits(led_o)-1:0] <= led_o;
					default: wb_dat_o <= '0;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sel_latch_hold_a: assert property ($past(captured) && captured |-> $stable(app_lat) && $stable(start_lat))
		else $error("captured selectors changed");
	cfg_error_raise_a: assert property (ce_i && captured
		&& (app_sel_i != app_lat || start_sel_i != start_lat) |=> err_cfg)
		else $error("selector change not flagged");
	state_led_a: assert property (!err_cfg |-> led_o.state == safe_out_o)
		else $error("output indicator mismatch");
	input_led_a: assert property (!$past(rst_i) && $past(ce_i) && !$past(sync_timeout_i) && !err_cfg
		|-> led_o.inputs == $past(in_active_i))
		else $error("input indicator mismatch");
	sync_alternate_a: assert property ($past(ce_i) && $past(sync_timeout_i) && !err_cfg
		|-> led_o.inputs[0] != led_o.inputs[1])
		else $error("sync inputs not alternating");
	safe_dark_a: assert property (safe_state_o |-> !safe_out_o)
		else $error("output on in safe state");
	alert_safe_a: assert property (ce_i && (sync_timeout_i || alert_i) |=> safe_state_o && !safe_out_o)
		else $error("alert did not force safe state");
	resume_a: assert property (ce_i && captured && !alert && !next_err_cfg && !next_err_gen
		&& out_request_i |=> safe_out_o)
		else $error("no resume after alert cleared");
	err_sticky_a: assert property (err_cfg || err_gen |=> (err_cfg || err_gen) && safe_state_o)
		else $error("error released before power-up");
	cfg_leds_a: assert property (err_cfg |-> led_o.error && led_o.state && led_o.start && (&led_o.inputs))
		else $error("configuration error pattern wrong");

endmodule

// ### verification/sml_bench.sv
// Purpose: Self-checking bench for the selector latch and indicator block
// Assumes: Flash half period of 4 cycles
// Notes: Outputs are read at rising edges, so the values seen are those before the edge
`timescale 1ns/1ps
module safety_module_config_status_leds_bench;
	logic clk_i = 0, rst_i = 1, cyc = 0, we = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wd = 32'h0, rd, q;
	logic ack, safe_out, safe_st, out_req = 0, met = 0, wt = 0, sync = 0, alrt = 0, err = 0;
	logic [3:0] app = 4'h3, stsel = 4'h5, inact = 4'h0;
	sml_pkg::sml_led_s led;
	integer num_errors = 0, checks = 0;
	sml_top #(.FLASH_HALF_CYC(32'h4)) sml_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd),
		.wb_dat_o(rd), .wb_ack_o(ack), .app_sel_i(app), .start_sel_i(stsel), .out_request_i(out_req),
		.start_met_i(met), .start_wait_i(wt), .in_active_i(inact), .sync_timeout_i(sync),
		.alert_i(alrt), .error_i(err), .safe_out_o(safe_out), .safe_state_o(safe_st), .led_o(led));
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task end_sim;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task cy(input integer n);
		repeat (n) @(posedge clk_i);
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		integer n;
		n = 0;
		cyc <= 1;
		we <= w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) begin
			num_errors++;
			end_sim();
		end
		r = rd;
		cyc <= 0;
		we <= 0;
		@(posedge clk_i);
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		cy(6);
		rst_i <= 0;
		out_req <= 1;
		inact <= 4'ha;
		met <= 1;
		cy(4);
		wb(0, 8'h08, 0, q); chk(q, 32'h53);
		chk(led.state, 1);
		chk(led.inputs, 4'ha);
		chk(led.start, 1);
		chk(safe_st, 0);
		wb(0, 8'h10, 0, q); chk(q, 0);
		wb(1, 8'h00, 32'h4, q);
		wb(0, 8'h00, 0, q); chk(q, 32'h4);
		$display("test normal done");
		met <= 0;
		wt <= 1;
		alrt <= 1;
		cy(3);
		chk(safe_out, 0);
		chk(safe_st, 1);
		chk(led.start, 0);
		chk(led.error, 0);
		cy(4);
		chk(led.error, 1);
		chk(led.start, 1);
		alrt <= 0;
		sync <= 1;
		cy(3);
		chk(led.inputs[1:0], 2'b10);
		chk(led.error, 0);
		chk(led.inputs[3:2], 2'b10);
		cy(4);
		chk(led.inputs[1:0], 2'b01);
		chk(led.error, 1);
		chk(safe_out, 0);
		sync <= 0;
		wt <= 0;
		cy(3);
		chk(safe_out, 1);
		chk(safe_st, 0);
		chk(led.error, 0);
		chk(led.start, 0);
		$display("test alert done");
		err <= 1;
		cy(1);
		err <= 0;
		cy(3);
		chk(led.error, 1);
		cy(4);
		chk(led.error, 1);
		chk(safe_out, 0);
		wb(0, 8'h04, 0, q); chk(q, 32'h1a);
		$display("test error done");
		rst_i <= 1;
		cy(2);
		rst_i <= 0;
		cy(3);
		chk(safe_out, 1);
		app <= 4'h6;
		cy(3);
		chk(led, 7'h7f);
		wb(0, 8'h04, 0, q); chk(q, 32'h19);
		wb(0, 8'h08, 0, q); chk(q, 32'h53);
		app <= 4'h3;
		cy(3);
		chk(safe_out, 0);
		chk(led, 7'h7f);
		$display("test config done");
		rst_i <= 1;
		cy(2);
		rst_i <= 0;
		cy(3);
		wb(0, 8'h04, 0, q); chk(q, 32'h10);
		stsel <= 4'h9;
		cy(3);
		chk(led, 7'h7f);
		wb(0, 8'h04, 0, q); chk(q, 32'h19);
		wb(0, 8'h08, 0, q); chk(q, 32'h53);
		wb(1, 8'h00, 32'h9, q);
		wb(0, 8'h00, 0, q); chk(q, 32'h9);
		$display("test start selector done");
		end_sim();
	end
endmodule
